// ==== hdl/usart_port_defines.svh ====
// Constants shared by both ends of the processor port: register selects,
// field positions, reset values and timing counts.
// Assumes inclusion by bare name from files on the hdl/ include path.
`ifndef USART_PORT_DEFINES_SVH
`define USART_PORT_DEFINES_SVH

// Register select codes seen on register_select
`define SEL_DATA            3'h0
`define SEL_STATUS1         3'h1
`define SEL_STATUS2         3'h2
`define SEL_COMMAND         3'h3
`define SEL_MODE            3'h4

// Status register 1 bit positions
`define SR1_TX_FREE         0
`define SR1_RX_AVAIL        1
`define SR1_IDLE_CHANGE     2
`define SR1_DATA_MODE       7

// Command register bit positions
`define CMD_BIT_ZERO        0
`define CMD_BIT_TWO         2

// Status register 2 interrupt enable positions
`define SR2_EN_INCOMING     5
`define SR2_EN_TEST         6
`define SR2_EN_GROUP        7

// Reset values
`define COMMAND_RESET       8'h00
`define MODE_RESET          8'h00
`define SR2_EN_RESET        3'h0

// Cycles after reset before pin change detection is trusted
`define WARM_CYCLES         2'h3

// Cycles the host holds chip enable low for one access
`define HOST_ACCESS_CYCLES  2'h3

// Host Wishbone byte offsets
`define WB_IRQ_STATUS       8'h20
`define WB_IRQ_MASK         8'h24

// Host interrupt status bit positions
`define IRQ_RX              0
`define IRQ_TX              1
`define IRQ_IDLE            2

`endif

// ==== hdl/usart_types_pkg.sv ====
// Types shared by both ends of the processor port.
// Assumes the constants header supplies every numeric value.
package usart_types_pkg;

    typedef logic [7:0] byte_t;
    typedef logic [2:0] reg_sel_t;

    typedef enum logic [1:0] {
        H_IDLE,
        H_ACCESS,
        H_ACK,
        H_GAP
    } host_state_t;

endpackage : usart_types_pkg

// ==== hdl/usart_bus_if.sv ====
// Parallel processor port joining the device end and the host end.
// Assumes both ends run on one clock; the three-state bus and the
// open-drain ready lines are resolved here with pull-ups, no high-Z.
`timescale 1ns/10ps
interface usart_bus_if;
    import usart_types_pkg::*;

    // Access control, driven by the host
    logic     chip_enable_n;
    logic     read_write;
    reg_sel_t register_select;

    // Data bus halves and resolved level
    byte_t    host_data_out;
    logic     host_data_oe;
    byte_t    dev_data_out;
    logic     dev_data_oe;
    byte_t    host_data_bus;

    // Open-drain ready lines: out, enable, resolved level
    logic     rx_char_available_n_o;
    logic     rx_char_available_n_oe;
    logic     rx_char_available_n;
    logic     tx_holding_free_n_o;
    logic     tx_holding_free_n_oe;
    logic     tx_holding_free_n;
    logic     tx_idle_or_line_change_n_o;
    logic     tx_idle_or_line_change_n_oe;
    logic     tx_idle_or_line_change_n;

    // Undriven bus floats high through the pull-up
    assign host_data_bus = dev_data_oe  ? dev_data_out :
                           host_data_oe ? host_data_out : 8'hff;
    assign rx_char_available_n =
        rx_char_available_n_oe ? rx_char_available_n_o : 1'b1;
    assign tx_holding_free_n =
        tx_holding_free_n_oe ? tx_holding_free_n_o : 1'b1;
    assign tx_idle_or_line_change_n =
        tx_idle_or_line_change_n_oe ? tx_idle_or_line_change_n_o : 1'b1;

    modport dev (
        input  chip_enable_n, read_write, register_select, host_data_bus,
        output dev_data_out, dev_data_oe,
        output rx_char_available_n_o, rx_char_available_n_oe,
        output tx_holding_free_n_o, tx_holding_free_n_oe,
        output tx_idle_or_line_change_n_o, tx_idle_or_line_change_n_oe
    );

    modport host (
        output chip_enable_n, read_write, register_select,
        output host_data_out, host_data_oe,
        input  host_data_bus,
        input  rx_char_available_n, tx_holding_free_n, tx_idle_or_line_change_n
    );

endinterface : usart_bus_if

// ==== hdl/usart_port_device.sv ====
// Device end of the processor port: register access, ready flags and
// the three open-drain ready lines.
// Assumes a serial receiver and transmitter on the user side on clk_sys,
// and modem status pins that arrive asynchronously.
//
// Behaviour
// - Eight-bit bus, bit 0 least significant
// - Host picks register with register select
// - Chip enable low performs access, else float
// - Direction low reads, high writes
// - Receive line is inverse receive-available flag
// - Receive line clears on read or disable
// - Ready lines are open-drain drivers
// - Transmit line is inverse transmit-free flag
// - Transmit line clears on load, needs enable
// - Idle line low on empty or modem change
// - Auxiliary changes gated by top enable bits
// - Idle line: status read clears modem change, load clears empty
// - Reset clears mode, command and status
// - Device idles until host writes control
// - Incoming call and test have own enables, other three share one
// - Data-mode change needs command bit two or zero
`include "usart_port_defines.svh"
`timescale 1ns/10ps
module usart_port_device (
    // System
    input  wire logic                   clk_sys,
    input  wire logic                   rst,
    // Processor port
    usart_bus_if.dev                    bus,
    // Receiver side
    input  wire usart_types_pkg::byte_t rx_char_in,
    input  wire logic                   rx_char_valid,
    // Transmitter side
    output usart_types_pkg::byte_t      tx_holding_reg,
    output logic                        tx_char_pending,
    input  wire logic                   tx_char_taken,
    input  wire logic                   tx_shift_done,
    // Modem status pins, asynchronous
    input  wire logic                   data_mode_input,
    input  wire logic                   receiver_ready_input,
    input  wire logic                   incoming_call_input,
    input  wire logic                   test_mode_input,
    input  wire logic                   signal_quality_input,
    input  wire logic                   standby_input,
    input  wire logic                   rate_indicator_input,
    // Control registers seen by the serial logic
    output usart_types_pkg::byte_t      command,
    output usart_types_pkg::byte_t      mode
);
    import usart_types_pkg::*;

    // Pin order: 0 data mode, 1 receiver ready, 2 incoming call, 3 test,
    // 4 signal quality, 5 standby, 6 rate indicator
    logic [6:0] pin_meta;
    logic [6:0] pin_sync;
    logic [6:0] pin_prev;
    logic [1:0] warm_cnt;

    byte_t      rx_holding_reg;
    logic       rx_available_flag;
    logic       tx_idle_state;
    logic       line_change;
    logic [2:0] aux_irq_enable;
    logic       ce_prev;

    wire  [6:0] pin_raw = {rate_indicator_input, standby_input,
                           signal_quality_input, test_mode_input,
                           incoming_call_input, receiver_ready_input,
                           data_mode_input};

    // Access decode; a request is acted on only at the falling edge of
    // chip enable, so a long read cannot clear a flag twice
    wire        selected  = ~bus.chip_enable_n;
    wire        acc_start = ce_prev & selected;
    wire        rd_start  = acc_start & ~bus.read_write;
    wire        wr_start  = acc_start & bus.read_write;
    wire        sel_data  = bus.register_select == `SEL_DATA;
    wire        sel_sr1   = bus.register_select == `SEL_STATUS1;
    wire        sel_sr2   = bus.register_select == `SEL_STATUS2;
    wire        sel_cmd   = bus.register_select == `SEL_COMMAND;
    wire        sel_mode  = bus.register_select == `SEL_MODE;
    wire        rd_rhr    = rd_start & sel_data;
    wire        rd_sr1    = rd_start & sel_sr1;
    wire        wr_thr    = wr_start & sel_data;

    // Enables come straight from the command register, cleared by reset
    wire        tx_enable = command[`CMD_BIT_ZERO];
    wire        rx_enable = command[`CMD_BIT_TWO];
    wire        tx_free_flag = ~tx_char_pending;

    // Change detection on synchronised pins
    wire        warm      = warm_cnt == `WARM_CYCLES;
    wire  [6:0] pin_edge  = warm ? (pin_sync ^ pin_prev) : 7'h00;
    wire        dm_change = pin_edge[0] &
                            (command[`CMD_BIT_TWO] | command[`CMD_BIT_ZERO]);
    wire        aux_change =
        (pin_edge[2] & aux_irq_enable[`SR2_EN_INCOMING - 5]) |
        (pin_edge[3] & aux_irq_enable[`SR2_EN_TEST - 5]) |
        (|pin_edge[6:4] & aux_irq_enable[`SR2_EN_GROUP - 5]);
    wire        change_event = dm_change | pin_edge[1] | aux_change;

    // Hardware set wins over the host's clear in the same cycle
    wire        next_rx_available = (rx_char_valid & rx_enable) |
                                    (rx_available_flag & ~rd_rhr & rx_enable);
    wire        next_tx_pending   = wr_thr | (tx_char_pending & ~tx_char_taken);
    wire        next_tx_idle      = tx_shift_done |
                                    (tx_idle_state & ~wr_thr);
    wire        next_line_change  = change_event | (line_change & ~rd_sr1);
    wire        idle_change_flag  = tx_idle_state | line_change;

    // Status register images; modem inputs read back inverted
    wire byte_t status1 = {~pin_sync[0], 4'h0, idle_change_flag,
                           rx_available_flag, tx_free_flag};
    wire byte_t status2 = {aux_irq_enable, ~pin_sync[6:2]};

    wire byte_t rd_mux  = sel_data ? rx_holding_reg :
                          sel_sr1  ? status1 :
                          sel_sr2  ? status2 :
                          sel_cmd  ? command :
                          sel_mode ? mode : 8'h00;

    // Pin synchroniser and change history
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pin_meta <= 7'h00;
            pin_sync <= 7'h00;
            pin_prev <= 7'h00;
            warm_cnt <= 2'h0;
        end else begin
            pin_meta <= pin_raw;
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
            if (!warm) begin
                warm_cnt <= warm_cnt + 2'h1;
            end
        end
    end

    // Host-written registers
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            command        <= `COMMAND_RESET;
            mode           <= `MODE_RESET;
            aux_irq_enable <= `SR2_EN_RESET;
            tx_holding_reg <= 8'h00;
        end else if (wr_start) begin
            if (sel_cmd) begin
                command <= bus.host_data_bus;
            end
            if (sel_mode) begin
                mode <= bus.host_data_bus;
            end
            if (sel_sr2) begin
                aux_irq_enable <= bus.host_data_bus[7:5];
            end
            if (sel_data) begin
                tx_holding_reg <= bus.host_data_bus;
            end
        end
    end

    // Receive holding register
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rx_holding_reg <= 8'h00;
        end else if (rx_char_valid && rx_enable) begin
            rx_holding_reg <= rx_char_in;
        end
    end

    // Status flags
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rx_available_flag <= 1'b0;
            tx_char_pending   <= 1'b0;
            tx_idle_state     <= 1'b0;
            line_change       <= 1'b0;
        end else begin
            rx_available_flag <= next_rx_available;
            tx_char_pending   <= next_tx_pending;
            tx_idle_state     <= next_tx_idle;
            line_change       <= next_line_change;
        end
    end

    // Read data is frozen at the start of the access so a flag cleared by
    // this read does not change the byte the host is sampling
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ce_prev          <= 1'b1;
            bus.dev_data_out <= 8'h00;
            bus.dev_data_oe  <= 1'b0;
        end else begin
            ce_prev         <= bus.chip_enable_n;
            bus.dev_data_oe <= selected & ~bus.read_write;
            if (rd_start) begin
                bus.dev_data_out <= rd_mux;
            end
        end
    end

    // Open-drain lines only ever pull low; enable high means pulling
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            bus.rx_char_available_n_o       <= 1'b0;
            bus.rx_char_available_n_oe      <= 1'b0;
            bus.tx_holding_free_n_o         <= 1'b0;
            bus.tx_holding_free_n_oe        <= 1'b0;
            bus.tx_idle_or_line_change_n_o  <= 1'b0;
            bus.tx_idle_or_line_change_n_oe <= 1'b0;
        end else begin
            bus.rx_char_available_n_oe      <= next_rx_available;
            bus.tx_holding_free_n_oe        <= ~next_tx_pending & tx_enable;
            bus.tx_idle_or_line_change_n_oe <= next_tx_idle | next_line_change;
        end
    end

endmodule : usart_port_device

// ==== hdl/usart_port_host.sv ====
// Host end of the processor port: a Wishbone slave that turns each device-range read, and each
// device-range write with wb_sel_i[0] set, into one chip-enable access, plus interrupt status and mask.
// Assumes the device end on the same clk_sys, so port levels need no
// synchroniser.
`include "usart_port_defines.svh"
`timescale 1ns/10ps
module usart_port_host (
    // System
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // Processor port
    usart_bus_if.host        bus,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    // Interrupt
    output logic             irq
);
    import usart_types_pkg::*;

    host_state_t state;
    logic [1:0]  acc_cnt;
    logic [2:0]  irq_status;
    logic [2:0]  irq_mask;
    logic [2:0]  line_prev;

    wire         req      = wb_cyc_i & wb_stb_i;
    wire         dev_hit  = wb_adr_i[7:5] == 3'h0;
    wire         dev_go   = dev_hit & (~wb_we_i | wb_sel_i[0]);
    wire         wr_stat  = wb_we_i & wb_sel_i[0] & (wb_adr_i == `WB_IRQ_STATUS);
    wire         wr_mask  = wb_we_i & wb_sel_i[0] & (wb_adr_i == `WB_IRQ_MASK);
    wire         local_go = (state == H_IDLE) & req & ~dev_go;
    wire         acc_last = acc_cnt == `HOST_ACCESS_CYCLES - 2'h1;

    // Active-low lines; an event is a fall of any of them
    wire [2:0]   line_now = {bus.tx_idle_or_line_change_n, bus.tx_holding_free_n,
                             bus.rx_char_available_n};
    wire [2:0]   line_fall = line_prev & ~line_now;
    wire [2:0]   stat_clr  = (local_go & wr_stat) ? wb_dat_i[2:0] : 3'h0;
    wire [2:0]   next_irq_status = line_fall | (irq_status & ~stat_clr);

    wire [31:0]  local_rd = (wb_adr_i == `WB_IRQ_STATUS) ? {29'h0, irq_status} :
                            (wb_adr_i == `WB_IRQ_MASK)   ? {29'h0, irq_mask} :
                            32'h0;

    // Access sequencer: chip enable low for a fixed count, then one ack,
    // then a gap so the device sees every access as a fresh edge
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state               <= H_IDLE;
            acc_cnt             <= 2'h0;
            bus.chip_enable_n   <= 1'b1;
            bus.read_write      <= 1'b1;
            bus.register_select <= 3'h0;
            bus.host_data_out   <= 8'h00;
            bus.host_data_oe    <= 1'b0;
            wb_dat_o            <= 32'h0;
            wb_ack_o            <= 1'b0;
        end else begin
            unique case (state)
                H_IDLE: begin
                    if (req && dev_go) begin
                        bus.chip_enable_n   <= 1'b0;
                        bus.read_write      <= wb_we_i;
                        bus.register_select <= wb_adr_i[4:2];
                        bus.host_data_out   <= wb_dat_i[7:0];
                        bus.host_data_oe    <= wb_we_i;
                        acc_cnt             <= 2'h0;
                        state               <= H_ACCESS;
                    end else if (req) begin
                        wb_dat_o <= local_rd;
                        wb_ack_o <= 1'b1;
                        state    <= H_ACK;
                    end
                end
                H_ACCESS: begin
                    acc_cnt <= acc_cnt + 2'h1;
                    if (acc_last) begin
                        wb_dat_o          <= bus.read_write ? 32'h0 :
                                             {24'h0, bus.host_data_bus};
                        bus.chip_enable_n <= 1'b1;
                        bus.host_data_oe  <= 1'b0;
                        wb_ack_o          <= 1'b1;
                        state             <= H_ACK;
                    end
                end
                H_ACK: begin
                    wb_ack_o <= 1'b0;
                    state    <= H_GAP;
                end
                H_GAP: begin
                    state <= H_IDLE;
                end
            endcase
        end
    end

    // Interrupt status, write one to clear; a new event wins over a clear
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            line_prev  <= 3'h7;
            irq_status <= 3'h0;
            irq_mask   <= 3'h0;
            irq        <= 1'b0;
        end else begin
            line_prev  <= line_now;
            irq_status <= next_irq_status;
            if (local_go && wr_mask) begin
                irq_mask <= wb_dat_i[2:0];
            end
            irq <= |(next_irq_status & irq_mask);
        end
    end

endmodule : usart_port_host

// ==== sim/usart_port_assertions.sv ====
// Concurrent checks on the processor port joining the device and host ends.
// Assumes one clk_sys domain and hookup to the interface's own signals.
`include "usart_port_defines.svh"
`timescale 1ns/10ps
module usart_port_assertions (
    // System
    input wire logic                      clk_sys,
    input wire logic                      rst,
    // Access control
    input wire logic                      chip_enable_n,
    input wire logic                      read_write,
    input wire usart_types_pkg::reg_sel_t register_select,
    // Data bus enables
    input wire logic                      host_data_oe,
    input wire logic                      dev_data_oe,
    // Open-drain ready lines
    input wire logic                      rx_char_available_n_o,
    input wire logic                      rx_char_available_n_oe,
    input wire logic                      tx_holding_free_n_o,
    input wire logic                      tx_holding_free_n_oe,
    input wire logic                      tx_idle_or_line_change_n_o,
    input wire logic                      tx_idle_or_line_change_n_oe
);
    import usart_types_pkg::*;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence rd_start(s);
        $fell(chip_enable_n) && !read_write && register_select == s;
    endsequence
    sequence wr_start(s);
        $fell(chip_enable_n) && read_write && register_select == s;
    endsequence

    a_float_unselected: assert property (
        chip_enable_n && $past(chip_enable_n) && $past(chip_enable_n, 2) |-> !dev_data_oe)
        else $error("data bus driven while not selected");
    a_read_drives: assert property (
        $fell(chip_enable_n) && !read_write |-> ##[1:2] dev_data_oe)
        else $error("read access left the bus undriven");
    a_write_no_drive: assert property (
        $fell(chip_enable_n) && read_write |-> (!dev_data_oe) [*3])
        else $error("device drove the bus during a write");
    a_no_contention: assert property (
        host_data_oe |-> !dev_data_oe)
        else $error("both ends drive the data bus");
    a_access_held: assert property (
        $fell(chip_enable_n) |=>
        (!chip_enable_n && $stable(register_select) && $stable(read_write)) [*2]
        ##1 chip_enable_n)
        else $error("access not held steady for its length");
    a_rx_read_clears: assert property (
        rd_start(`SEL_DATA) |-> ##[1:3] !rx_char_available_n_oe)
        else $error("receive line still pulled after data read");
    a_thr_load_clears: assert property (
        wr_start(`SEL_DATA) |-> ##[1:3] !tx_holding_free_n_oe)
        else $error("transmit line still pulled after load");
    a_open_drain: assert property (
        !rx_char_available_n_o && !tx_holding_free_n_o && !tx_idle_or_line_change_n_o)
        else $error("ready line drives high");
    a_reset_quiet: assert property (disable iff (1'b0)
        $fell(rst) |-> chip_enable_n && !dev_data_oe && !rx_char_available_n_oe
        && !tx_holding_free_n_oe && !tx_idle_or_line_change_n_oe)
        else $error("port not quiet after reset");
endmodule : usart_port_assertions

// ==== sim/tb_usart_host_bus_interface.sv ====
// Self-checking bench: Wishbone master drives the host end, which talks to
// the device end over the port; serial and modem sides driven directly.
`include "usart_port_defines.svh"
`timescale 1ns/10ps
module tb_usart_host_bus_interface;
    import usart_types_pkg::*;
    typedef struct packed {logic w; logic [7:0] a; byte_t d; byte_t e;} row_t;
    logic        clk_sys, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq;
    logic [7:0]  wb_adr_i;
    logic [31:0] wb_dat_i, wb_dat_o, q;
    logic [3:0]  wb_sel_i;
    byte_t       rx_char_in, tx_holding_reg, command, mode;
    logic        rx_char_valid, tx_char_pending, tx_char_taken, tx_shift_done;
    logic        data_mode_input, receiver_ready_input, incoming_call_input;
    logic        test_mode_input, signal_quality_input, standby_input;
    logic        rate_indicator_input;
    int          errors, num_checks, cycles;
    // Write rows expect zero read data
    row_t rows [11] = '{'{0, 8'h0c, 8'h00, 8'h00}, '{0, 8'h10, 8'h00, 8'h00},
        '{0, 8'h24, 8'h00, 8'h00}, '{1, 8'h10, 8'ha5, 8'h00}, '{0, 8'h10, 8'h00, 8'ha5},
        '{1, 8'h08, 8'h4a, 8'h00}, '{0, 8'h08, 8'h00, 8'h5f}, '{1, 8'h14, 8'hff, 8'h00},
        '{0, 8'h14, 8'h00, 8'h00}, '{1, 8'h0c, 8'h04, 8'h00}, '{0, 8'h0c, 8'h00, 8'h04}};

    usart_bus_if bus_a ();
    usart_port_device usart_port_device_i (.clk_sys, .rst, .bus(bus_a), .rx_char_in,
        .rx_char_valid, .tx_holding_reg, .tx_char_pending, .tx_char_taken, .tx_shift_done,
        .data_mode_input, .receiver_ready_input, .incoming_call_input, .test_mode_input,
        .signal_quality_input, .standby_input, .rate_indicator_input, .command, .mode);
    usart_port_host usart_port_host_i (.clk_sys, .rst, .bus(bus_a), .wb_cyc_i, .wb_stb_i,
        .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_dat_o, .wb_ack_o, .irq);
    usart_port_assertions usart_port_assertions_i (.clk_sys, .rst,
        .chip_enable_n(bus_a.chip_enable_n), .read_write(bus_a.read_write),
        .register_select(bus_a.register_select), .host_data_oe(bus_a.host_data_oe),
        .dev_data_oe(bus_a.dev_data_oe), .rx_char_available_n_o(bus_a.rx_char_available_n_o),
        .rx_char_available_n_oe(bus_a.rx_char_available_n_oe),
        .tx_holding_free_n_o(bus_a.tx_holding_free_n_o),
        .tx_holding_free_n_oe(bus_a.tx_holding_free_n_oe),
        .tx_idle_or_line_change_n_o(bus_a.tx_idle_or_line_change_n_o),
        .tx_idle_or_line_change_n_oe(bus_a.tx_idle_or_line_change_n_oe));

    task chk(input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, s, e);
        end
    endtask : chk

    task tally_and_finish;
        if (errors == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    // Classic single cycle; waits for ack with no assumed latency
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge clk_sys);
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        repeat (3) @(posedge clk_sys);
    endtask : wb

    // Flip side input k (0 rx valid, 1 tx taken, 2 shift done, 3 data mode,
    // 4 test, 5 incoming call, 6 receiver ready, 7 signal quality); a pulse
    // flips it back one cycle later, then sync and ready lines settle
    task automatic hit(input int k, input logic pulse);
        repeat (pulse ? 2 : 1) begin
            @(posedge clk_sys);
            case (k)
                0: rx_char_valid <= ~rx_char_valid;
                1: tx_char_taken <= ~tx_char_taken;
                2: tx_shift_done <= ~tx_shift_done;
                3: data_mode_input <= ~data_mode_input;
                4: test_mode_input <= ~test_mode_input;
                5: incoming_call_input <= ~incoming_call_input;
                6: receiver_ready_input <= ~receiver_ready_input;
                default: signal_quality_input <= ~signal_quality_input;
            endcase
        end
        repeat (6) @(posedge clk_sys);
    endtask : hit

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            tally_and_finish;
        end
    end

    initial begin
        {rst, wb_sel_i} = 5'h1f;
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
        {rx_char_in, rx_char_valid, tx_char_taken, tx_shift_done} = '0;
        {data_mode_input, receiver_ready_input, incoming_call_input} = '0;
        {test_mode_input, signal_quality_input, standby_input, rate_indicator_input} = '0;
        {errors, num_checks, cycles} = '0;
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        foreach (rows[i]) begin
            wb(rows[i].w, rows[i].a, {24'h0, rows[i].d});
            chk(q, {24'h0, rows[i].e});
        end
        chk(command, 8'h04);
        rx_char_in <= 8'h3c;
        hit(0, 1);
        chk(bus_a.rx_char_available_n, 0);
        wb(0, 8'h04, 0);
        chk(q[`SR1_RX_AVAIL], 1);
        wb(0, 8'h00, 0);
        chk(q, 32'h3c);
        chk(bus_a.rx_char_available_n, 1);
        hit(0, 1);
        wb(1, 8'h0c, 32'h01);
        chk(bus_a.rx_char_available_n, 1);
        wb(1, 8'h00, 32'h81);
        chk({tx_char_pending, tx_holding_reg}, 9'h181);
        chk(bus_a.tx_holding_free_n, 1);
        hit(1, 1);
        chk(bus_a.tx_holding_free_n, 0);
        wb(1, 8'h0c, 32'h00);
        chk(bus_a.tx_holding_free_n, 1);
        hit(3, 0);
        chk(bus_a.tx_idle_or_line_change_n, 1);
        wb(1, 8'h0c, 32'h04);
        hit(3, 0);
        chk(bus_a.tx_idle_or_line_change_n, 0);
        wb(0, 8'h04, 0);
        chk(q[`SR1_DATA_MODE], 1);
        chk(bus_a.tx_idle_or_line_change_n, 1);
        hit(4, 0);
        chk(bus_a.tx_idle_or_line_change_n, 0);
        wb(0, 8'h04, 0);
        hit(5, 0);
        chk(bus_a.tx_idle_or_line_change_n, 1);
        hit(6, 0);
        chk(bus_a.tx_idle_or_line_change_n, 0);
        wb(1, 8'h08, 32'h80);
        wb(0, 8'h04, 0);
        hit(7, 0);
        chk(bus_a.tx_idle_or_line_change_n, 0);
        wb(0, 8'h04, 0);
        hit(2, 1);
        chk(bus_a.tx_idle_or_line_change_n, 0);
        wb(0, 8'h04, 0);
        chk(bus_a.tx_idle_or_line_change_n, 0);
        wb(1, 8'h00, 32'h55);
        chk(bus_a.tx_idle_or_line_change_n, 1);
        wb(0, `WB_IRQ_STATUS, 0);
        chk(q, 32'h7);
        chk(irq, 0);
        wb(1, `WB_IRQ_MASK, 32'h2);
        chk(irq, 1);
        wb(1, `WB_IRQ_STATUS, 32'h2);
        chk(irq, 0);
        wb(0, `WB_IRQ_STATUS, 0);
        chk(q, 32'h5);
        hit(2, 1);
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        chk({irq, command, mode, bus_a.tx_idle_or_line_change_n}, 18'h1);
        wb(0, 8'h0c, 0);
        chk(q, 32'h0);
        tally_and_finish;
    end
endmodule : tb_usart_host_bus_interface
